// ### nbc_cfg.svh
// constants for the packed-decimal / binary numeric converter
//
// Contract
// - two modes, decimal-to-binary and binary-to-decimal; decimal-to-binary when the select is low.
// - in decimal-to-binary mode a digit above 9 counts as 9 up to magnitude 161061273; beyond it, as when the top digit is above 9, the code gives +/-9999999.
// - decimal-to-binary mode outputs the binary value of the packed digits.
// - decimal-to-binary input beyond +/-161061273 gives +/-9999999.
// - binary-to-decimal mode outputs the magnitude as packed four-bit digits.
// - binary-to-decimal input beyond +/-9999999 gives +/-161061273.
// - sign-magnitude values, bit 31 is the sign, conversion on magnitude only.
// - enable low holds the converter reset and forces output to zero.
`ifndef NBC_CFG_SVH
`define NBC_CFG_SVH
`define NBC_WIDTH        32
`define NBC_SIGN_BIT     31
`define NBC_DIGITS       7
`define NBC_DIGIT_MAX    4'h9
`define NBC_PACKED_LIMIT 31'h0999_9999
`define NBC_BIN_LIMIT    31'h0098_967f
`define NBC_OUT_RESET    32'h0000_0000
`endif

// ### nbc_pkg.sv
// types for the numeric converter
package nbc_pkg;
  typedef enum logic {
    NBC_TO_BINARY,
    NBC_TO_PACKED
  } nbc_mode_type;

  typedef struct packed {
    logic        enable;
    nbc_mode_type mode;
    logic [31:0] value;
  } nbc_req_type;

  typedef struct packed {
    logic [31:0] value;
  } nbc_state_type;
endpackage

// ### nbc_digit_lane.sv
// one decimal digit lane: clamp for decoding, add-3 step for encoding
`timescale 1ns/1ps
`include "nbc_cfg.svh"
module nbc_digit_lane (
  // digit in
  input  wire logic [3:0] digit_in,
  // results
  output logic      [3:0] clamped_out,
  output logic      [3:0] adjusted_out
);
  // clamp out-of-range digit and apply double-dabble correction
  always_comb begin
    clamped_out  = (digit_in > `NBC_DIGIT_MAX) ? `NBC_DIGIT_MAX : digit_in;
    adjusted_out = (digit_in > 4'h4) ? 4'(digit_in + 4'h3) : digit_in;
  end
endmodule

// ### nbc_converter.sv
// packed-decimal / binary numeric converter, registered output
`timescale 1ns/1ps
`include "nbc_cfg.svh"
module nbc_converter #(
  parameter int DIGITS = `NBC_DIGITS
) (
  // clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  // control
  input  wire logic                 enable_in,
  input  wire logic                 to_packed_decimal_mode_in,
  // data
  input  wire logic [31:0]          conversion_input_in,
  output logic      [31:0]          conversion_output_out
);
  // magnitude bits below the sign, one encoder stage per bit
  localparam int MAG_BITS = `NBC_SIGN_BIT;

  nbc_pkg::nbc_state_type state_q;
  nbc_pkg::nbc_state_type state_d;
  nbc_pkg::nbc_mode_type  mode;
  logic                   sign;
  logic [30:0]            mag;
  logic [DIGITS*4-1:0]    clamped;
  logic [30:0]            dec_bin;
  logic [30:0]            enc_bcd;
  logic [30:0]            dec_mag;
  logic [30:0]            enc_mag;
  logic [DIGITS*4-1:0]    dd_stage [0:MAG_BITS];
  logic [DIGITS*4-1:0]    dd_adj   [0:MAG_BITS-1];

  // mode selection, decimal-to-binary when the select is low
  assign mode = to_packed_decimal_mode_in ? nbc_pkg::NBC_TO_PACKED
                                          : nbc_pkg::NBC_TO_BINARY;
  // split sign and magnitude
  assign sign = conversion_input_in[`NBC_SIGN_BIT];
  assign mag  = conversion_input_in[30:0];

  // clamp each packed digit
  genvar g;
  generate
    for (g = 0; g < DIGITS; g++) begin : g_lane
      nbc_digit_lane u_lane (
        .digit_in     (mag[g*4 +: 4]),
        .clamped_out  (clamped[g*4 +: 4]),
        .adjusted_out ()
      );
    end
  endgenerate

  // weighted sum of clamped digits
  function automatic logic [30:0] packed_to_bin(input logic [DIGITS*4-1:0] d);
    logic [30:0] acc;
    acc = 31'h0;
    for (int i = DIGITS - 1; i >= 0; i--) begin
      acc = 31'(acc * 31'd10 + 31'(d[i*4 +: 4]));
    end
    return acc;
  endfunction

  // true when bits 30:28 are zero and each of the seven nibbles below them is a legal decimal digit
  function automatic logic digits_ok(input logic [30:0] v);
    logic ok;
    ok = ((v >> (DIGITS*4)) == 31'h0);
    for (int i = 0; i < DIGITS; i++) begin
      if (v[i*4 +: 4] > `NBC_DIGIT_MAX) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // shift-add-3 ladder: each stage corrects every digit lane, then shifts in one bit
  assign dd_stage[0] = '0;
  genvar s;
  genvar k;
  generate
    for (s = 0; s < MAG_BITS; s++) begin : g_stage
      for (k = 0; k < DIGITS; k++) begin : g_digit
        nbc_digit_lane u_adj (
          .digit_in     (dd_stage[s][k*4 +: 4]),
          .clamped_out  (),
          .adjusted_out (dd_adj[s][k*4 +: 4])
        );
      end
      // corrected digits move up, the next magnitude bit enters at the bottom
      assign dd_stage[s+1] = {dd_adj[s][DIGITS*4-2:0], mag[MAG_BITS-1-s]};
    end
  endgenerate

  assign dec_bin = packed_to_bin(clamped);
  assign enc_bcd = 31'(dd_stage[MAG_BITS]);
  // saturate beyond the working range
  assign dec_mag = (mag > `NBC_PACKED_LIMIT) ? `NBC_BIN_LIMIT : dec_bin;
  assign enc_mag = (mag > `NBC_BIN_LIMIT) ? `NBC_PACKED_LIMIT : enc_bcd;

  // next state
  always_comb begin
    state_d = state_q;
    if (!enable_in) begin
      state_d.value = `NBC_OUT_RESET;
    end else if (mode == nbc_pkg::NBC_TO_BINARY) begin
      state_d.value = {sign, dec_mag};
    end else begin
      state_d.value = {sign, enc_mag};
    end
  end

  // state register
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q.value <= `NBC_OUT_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign conversion_output_out = state_q.value;

  // checks
  a_disable_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    !enable_in |=> conversion_output_out == 32'h0)
    else $error("output not zero after disable");
  a_sign_kept: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in |=> conversion_output_out[31] == $past(conversion_input_in[31]))
    else $error("sign not carried");
  a_dec_sat: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in && !to_packed_decimal_mode_in && conversion_input_in[30:0] > 31'h0999_9999
    |=> conversion_output_out[30:0] == 31'd9999999)
    else $error("decode saturation wrong");
  a_enc_sat: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in && to_packed_decimal_mode_in && conversion_input_in[30:0] > 31'd9999999
    |=> conversion_output_out[30:0] == 31'h0999_9999)
    else $error("encode saturation wrong");
  a_digit_clamp: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in && !to_packed_decimal_mode_in && conversion_input_in == 32'h0000_000e
    |=> conversion_output_out == 32'h0000_0009)
    else $error("digit not clamped to nine");
  a_dec_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in && !to_packed_decimal_mode_in && conversion_input_in == 32'h0000_0013
    |=> conversion_output_out == 32'h0000_000d)
    else $error("decode value wrong");
  a_enc_value: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in && to_packed_decimal_mode_in && conversion_input_in == 32'h0000_000b
    |=> conversion_output_out == 32'h0000_0011)
    else $error("encode value wrong");
  sequence s_enabled_change;
    enable_in && $changed(conversion_input_in);
  endsequence
  a_update_each: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_enabled_change ##0 (conversion_input_in[30:0] == 31'h0 && !conversion_input_in[31])
    |=> conversion_output_out == 32'h0)
    else $error("output not updated");
  a_mode_default: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in && !to_packed_decimal_mode_in && conversion_input_in == 32'h0000_0010
    |=> conversion_output_out == 32'h0000_000a)
    else $error("low select is not decode");

  // scan kinds shared by the mode-specific checks
  sequence s_dec_scan;
    enable_in && !to_packed_decimal_mode_in;
  endsequence
  sequence s_enc_scan;
    enable_in && to_packed_decimal_mode_in;
  endsequence

  // decode path
  a_clamp_nine: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_dec_scan ##0 (conversion_input_in[30:4] == 27'h0 && !digits_ok(conversion_input_in[30:0]))
    |=> conversion_output_out[30:0] == 31'd9)
    else $error("single digit above nine not read as nine");

  a_dec_single: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_dec_scan ##0 (conversion_input_in[30:0] < 31'h0a)
    |=> conversion_output_out[30:0] == $past(conversion_input_in[30:0]))
    else $error("single digit decode wrong");

  a_dec_tens: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_dec_scan ##0 (conversion_input_in[30:8] == 23'h0 && digits_ok(conversion_input_in[30:0]))
    |=> conversion_output_out[30:0] == 31'd10 * 31'($past(conversion_input_in[7:4]))
                                       + 31'($past(conversion_input_in[3:0])))
    else $error("two digit decode wrong");

  a_dec_top: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_dec_scan ##0 (conversion_input_in[30:28] != 3'h0)
    |=> conversion_output_out[30:0] == 31'd9999999)
    else $error("high magnitude bits not saturated");

  a_dec_bound: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_dec_scan |=> conversion_output_out[30:0] <= 31'd9999999)
    else $error("decode result out of range");

  // encode path
  a_enc_digits: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_enc_scan |=> digits_ok(conversion_output_out[30:0]))
    else $error("encode result holds an illegal digit");

  a_enc_single: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_enc_scan ##0 (conversion_input_in[30:0] < 31'd10)
    |=> conversion_output_out[30:0] == $past(conversion_input_in[30:0]))
    else $error("single digit encode wrong");

  a_enc_tens: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_enc_scan ##0 (conversion_input_in[30:0] > 31'd9 && conversion_input_in[30:0] < 31'd20)
    |=> conversion_output_out[30:0] == 31'h10 + $past(conversion_input_in[30:0]) - 31'd10)
    else $error("teens encode wrong");

  a_enc_bound: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_enc_scan |=> conversion_output_out[30:0] <= 31'h0999_9999)
    else $error("encode result out of range");

  a_neg_enc_sat: assert property (@(posedge mclk_in) disable iff (rst_in)
    s_enc_scan ##0 (conversion_input_in[31] && conversion_input_in[30:0] > 31'd9999999)
    |=> conversion_output_out == 32'h8999_9999)
    else $error("negative encode saturation wrong");

  // both modes
  a_zero_tracks: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in |=> ((conversion_output_out[30:0] == 31'h0)
                   == ($past(conversion_input_in[30:0]) == 31'h0)))
    else $error("zero output does not track zero input");

  a_neg_zero: assert property (@(posedge mclk_in) disable iff (rst_in)
    enable_in && conversion_input_in == 32'h8000_0000 |=> conversion_output_out == 32'h8000_0000)
    else $error("negative zero not kept");
endmodule

// ### nbc_user_prog.sv
// user-logic operand source that feeds the converter
`timescale 1ns/1ps
module nbc_user_prog (
  // request from the program
  input  wire nbc_pkg::nbc_req_type req_in,
  // operands to the converter
  output logic                      enable_out,
  output logic                      mode_out,
  output logic [31:0]               value_out
);
  // operands follow the program's current request, one scan per cycle
  assign enable_out = req_in.enable;
  assign mode_out   = req_in.mode;
  assign value_out  = req_in.value;
endmodule

// ### test_nbc_converter.sv
// self-checking bench for the numeric converter
`timescale 1ns/1ps
module test_nbc_converter;
  logic                 mclk_in;
  logic                 rst_in;
  logic                 en_w;
  logic                 md_w;
  logic [31:0]          din_w;
  logic [31:0]          dout_w;
  nbc_pkg::nbc_req_type req;
  int                   errors;
  int                   checked;

  nbc_user_prog prog (.req_in(req), .enable_out(en_w), .mode_out(md_w), .value_out(din_w));

  nbc_converter dut (
    .mclk_in(mclk_in), .rst_in(rst_in), .enable_in(en_w), .to_packed_decimal_mode_in(md_w),
    .conversion_input_in(din_w), .conversion_output_out(dout_w));

  // 10 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end

  task check32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one scan: drive just after an edge, result is due one edge later
  task apply(input string nm, input logic en, input logic md, input logic [31:0] v,
             input logic [31:0] exp);
    req <= '{enable: en, mode: nbc_pkg::nbc_mode_type'(md), value: v};
    @(posedge mclk_in);
    #1;
    check32(nm, exp, dout_w);
  endtask

  task t_decode;
    apply("dec_13", 1'b1, 1'b0, 32'h0000_0013, 32'h0000_000d);
    apply("dec_7", 1'b1, 1'b0, 32'h0000_0007, 32'h0000_0007);
    apply("dec_10", 1'b1, 1'b0, 32'h0000_0010, 32'h0000_000a);
    apply("dec_clamp", 1'b1, 1'b0, 32'h0000_000e, 32'h0000_0009);
    apply("dec_neg", 1'b1, 1'b0, 32'h8000_f0e9, 32'h8000_238b);
    apply("dec_max", 1'b1, 1'b0, 32'h0999_9999, 32'h0098_967f);
    apply("dec_over", 1'b1, 1'b0, 32'h0a00_0000, 32'h0098_967f);
    apply("dec_under", 1'b1, 1'b0, 32'h8a00_0000, 32'h8098_967f);
    apply("dec_big", 1'b1, 1'b0, 32'h7fff_ffff, 32'h0098_967f);
  endtask

  task t_encode;
    apply("enc_11", 1'b1, 1'b1, 32'h0000_000b, 32'h0000_0011);
    apply("enc_7", 1'b1, 1'b1, 32'h0000_0007, 32'h0000_0007);
    apply("enc_19", 1'b1, 1'b1, 32'h0000_0013, 32'h0000_0019);
    apply("enc_max", 1'b1, 1'b1, 32'h0098_967f, 32'h0999_9999);
    apply("enc_over", 1'b1, 1'b1, 32'h0098_9680, 32'h0999_9999);
    apply("enc_neg", 1'b1, 1'b1, 32'h8000_f0e9, 32'h8006_1673);
    apply("enc_negzero", 1'b1, 1'b1, 32'h8000_0000, 32'h8000_0000);
    apply("enc_under", 1'b1, 1'b1, 32'h8098_9680, 32'h8999_9999);
  endtask

  task t_enable;
    apply("en_off", 1'b0, 1'b1, 32'h0000_000b, 32'h0000_0000);
    apply("en_on", 1'b1, 1'b0, 32'h0000_0013, 32'h0000_000d);
    apply("en_next", 1'b1, 1'b1, 32'h0000_0013, 32'h0000_0019);
    apply("en_zero", 1'b1, 1'b1, 32'h0000_0000, 32'h0000_0000);
  endtask

  // reset in mid-run: output clears at once, low select decodes afterwards
  task t_reset;
    apply("pre_rst", 1'b1, 1'b1, 32'h0000_000b, 32'h0000_0011);
    rst_in = 1'b1;
    @(posedge mclk_in);
    #1;
    check32("rst_mid", 32'h0000_0000, dout_w);
    rst_in = 1'b0;
    apply("post_rst", 1'b1, 1'b0, 32'h0000_0013, 32'h0000_000d);
  endtask

  task conclude;
    if (errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // reset, then the scenarios back to back
  initial begin
    errors = 0;
    checked = 0;
    rst_in = 1'b1;
    req = '{enable: 1'b1, mode: nbc_pkg::NBC_TO_BINARY, value: 32'h0000_0013};
    repeat (3) @(posedge mclk_in);
    #1;
    check32("reset", 32'h0000_0000, dout_w);
    rst_in = 1'b0;
    t_decode;
    t_encode;
    t_enable;
    t_reset;
    conclude;
  end
endmodule
